// ---- inc/sr_ctrl_regs.vh ----
// Purpose: constants for the self refresh controller and its register map
// Assumes: 25 MHz controller clock
// Notes: times in ns, counts derived from the clock period
`ifndef SR_CTRL_REGS_VH
`define SR_CTRL_REGS_VH
`define CLK_PERIOD_NS 40
// Avalon word addresses of the controller's own registers
`define REG_CTRL 2'h0
`define REG_STATUS 2'h1
`define REG_MASKS 2'h2
// Control register fields
`define CTRL_ENTER_BIT 0
`define CTRL_EXIT_BIT 1
`define CTRL_MRW_BIT 2
// Status register fields
`define ST_BUSY_BIT 0
`define ST_IN_SR_BIT 1
`define ST_REF_OWED_BIT 2
`define ST_STATE_LSB 4
// Device mode register addresses and the mask reset value
`define MR_BANK_MASK 8'h10
`define MR_SEG_MASK 8'h11
`define MASK_RESET 8'h00
// Timing in ns and derived counts (least times round up)
`define MIN_SR_RESIDENCY_NS 15
`define SR_EXIT_DELAY_NS 220
`define RESIDENCY_CYC ((`MIN_SR_RESIDENCY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EXIT_DELAY_CYC ((`SR_EXIT_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STABLE_CLK_CYC 2
`define MRW_GAP_CYC 5
`endif

// ---- rtl/cmd_encoder.v ----
// Purpose: builds command/address words for the rising and falling halves
// Assumes: 10-bit CA bus, CS low selects
// Notes: pure combinational lookup
`timescale 1ns/100ps
`default_nettype none
module cmd_encoder (
    // Command select
    input wire [1:0] kind_in,
    input wire [7:0] ma_in,
    input wire [7:0] op_in,
    // Encoded words
    output reg cs_n_out,
    output reg [9:0] ca_rise_out,
    output reg [9:0] ca_fall_out
);
    localparam K_NOP = 2'h0;
    localparam K_SRE = 2'h1;
    localparam K_MRW = 2'h2;
    localparam K_REF = 2'h3;
    // Decode of the command kind
    always @* begin
        cs_n_out = 1'b0;
        ca_rise_out = 10'h007;
        ca_fall_out = 10'h000;
        case (kind_in)
            K_SRE: begin
                ca_rise_out = 10'h004;
            end
            K_MRW: begin
                ca_rise_out = {ma_in[7:2], 4'h0};
                ca_fall_out = {op_in, ma_in[1:0]};
            end
            K_REF: begin
                ca_rise_out = 10'h00c; // CA3 high: all-bank refresh
            end
            default: begin
                cs_n_out = 1'b1; // Deselect acts as NOP
                ca_rise_out = 10'h007;
            end
        endcase
    end
endmodule
`default_nettype wire

// ---- rtl/cycle_timer.v ----
// Purpose: loadable down counter with done flag
// Assumes: load wins over counting
// Notes: done high while count is zero
`timescale 1ns/100ps
`default_nettype none
module cycle_timer #(
    parameter W = 16
) (
    // Clock and reset
    input wire clk_in,
    input wire rst_in,
    // Control
    input wire load_in,
    input wire [W-1:0] value_in,
    // Status
    output wire done_out
);
    reg [W-1:0] count;
    // Count down to zero
    always @(posedge clk_in) begin
        if (rst_in) begin
            count <= {W{1'b0}};
        end else if (load_in) begin
            count <= value_in;
        end else if (count != {W{1'b0}}) begin
            count <= count - 1'b1;
        end
    end
    assign done_out = (count == {W{1'b0}});
endmodule
`default_nettype wire

// ---- rtl/sr_host_ctrl.v ----
// Purpose: drives an LPDDR2 device into and out of self refresh
// Assumes: banks idle when software requests entry or mask writes
// Notes: clock to the device is gated with ck_en_out during self refresh
`timescale 1ns/100ps
`default_nettype none
`include "sr_ctrl_regs.vh"
module sr_host_ctrl #(
    parameter TW = 16
) (
    // Clock and reset
    input wire clk_in,
    input wire rst_in,
    // Avalon-MM slave
    input wire [1:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    output reg [31:0] avs_readdata_out,
    output reg avs_waitrequest_out,
    // Device pins
    output reg ck_en_out,
    output reg cke_out,
    output reg cs_n_out,
    output reg [9:0] ca_rise_out,
    output reg [9:0] ca_fall_out,
    // Self refresh time accumulated (cycles)
    output reg [31:0] sr_time_out
);
    localparam S_IDLE = 4'h0;
    localparam S_PRE = 4'h1;
    localparam S_ENTER = 4'h2;
    localparam S_NOP = 4'h3;
    localparam S_SELF = 4'h4;
    localparam S_CLKUP = 4'h5;
    localparam S_CKEUP = 4'h6;
    localparam S_XSR = 4'h7;
    localparam S_MRW1 = 4'h8;
    localparam S_MRW2 = 4'h9;
    localparam S_MRWGAP = 4'ha;
    localparam S_REF = 4'hb;
    localparam K_NOP = 2'h0;
    localparam K_SRE = 2'h1;
    localparam K_MRW = 2'h2;
    localparam K_REF = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    reg [3:0] state;
    reg [3:0] next_state;
    reg [7:0] bank_mask;
    reg [7:0] seg_mask;
    reg mrw_second;
    reg ref_owed;
    reg enter_req;
    reg exit_req;
    reg mrw_req;
    reg [1:0] kind;
    reg [7:0] ma;
    reg [7:0] op;
    reg load;
    reg [TW-1:0] load_val;
    wire timer_done;
    wire enc_cs_n;
    wire [9:0] enc_rise;
    wire [9:0] enc_fall;

    // Width-safe conversion of a cycle count
    function [TW-1:0] cyc;
        input integer n;
        begin
            cyc = n[TW-1:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Submodules
    cycle_timer #(.W(TW)) timer (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .load_in(load),
        .value_in(load_val),
        .done_out(timer_done)
    );

    cmd_encoder enc (
        .kind_in(kind),
        .ma_in(ma),
        .op_in(op),
        .cs_n_out(enc_cs_n),
        .ca_rise_out(enc_rise),
        .ca_fall_out(enc_fall)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Command selection and sequencing
    always @* begin
        next_state = state;
        kind = K_NOP;
        ma = `MR_BANK_MASK;
        op = bank_mask;
        load = 1'b0;
        load_val = {TW{1'b0}};
        if (mrw_second) begin
            ma = `MR_SEG_MASK;
            op = seg_mask;
        end
        case (state)
            S_IDLE: begin
                if (mrw_req) begin
                    next_state = S_MRW1;
                end else if (enter_req && ref_owed) begin
                    next_state = S_REF;
                end else if (enter_req) begin
                    next_state = S_PRE;
                end
            end
            S_REF: begin
                kind = K_REF; // Resyncs device bank count
                load = 1'b1;
                load_val = cyc(`MRW_GAP_CYC);
                next_state = S_MRWGAP;
            end
            S_PRE: begin
                next_state = S_ENTER; // CKE still high this cycle
            end
            S_ENTER: begin
                kind = K_SRE;
                next_state = S_NOP;
            end
            S_NOP: begin
                load = 1'b1;
                load_val = cyc(`RESIDENCY_CYC);
                next_state = S_SELF;
            end
            S_SELF: begin
                if (exit_req && timer_done) begin
                    load = 1'b1;
                    load_val = cyc(`STABLE_CLK_CYC);
                    next_state = S_CLKUP;
                end
            end
            S_CLKUP: begin
                if (timer_done) begin
                    next_state = S_CKEUP;
                end
            end
            S_CKEUP: begin
                load = 1'b1;
                load_val = cyc(`EXIT_DELAY_CYC);
                next_state = S_XSR;
            end
            S_XSR: begin
                if (timer_done) begin
                    next_state = S_IDLE;
                end
            end
            S_MRW1: begin
                kind = K_MRW;
                load = 1'b1;
                load_val = cyc(`MRW_GAP_CYC);
                next_state = S_MRWGAP;
            end
            S_MRWGAP: begin
                if (timer_done && mrw_second) begin
                    next_state = S_MRW1; // Segment mask write follows
                end else if (timer_done) begin
                    next_state = S_IDLE;
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // State, pins and bookkeeping
    always @(posedge clk_in) begin
        if (rst_in) begin
            state <= S_IDLE;
            cke_out <= 1'b1;
            ck_en_out <= 1'b1;
            cs_n_out <= 1'b1;
            ca_rise_out <= 10'h007;
            ca_fall_out <= 10'h000;
            ref_owed <= 1'b0;
            mrw_second <= 1'b0;
            sr_time_out <= 32'h00000000;
        end else begin
            state <= next_state;
            cs_n_out <= enc_cs_n;
            ca_rise_out <= enc_rise;
            ca_fall_out <= enc_fall;
            // CKE falls with the entry command, low until exit
            if (state == S_ENTER) begin
                cke_out <= 1'b0;
            end else if (next_state == S_CKEUP) begin
                cke_out <= 1'b1; // held high through exit delay
            end
            // Clock stops one cycle after entry, restarts early
            if (state == S_NOP) begin
                ck_en_out <= 1'b0;
            end else if (next_state == S_CLKUP) begin
                ck_en_out <= 1'b1;
            end
            // Refresh owed after every exit
            if (state == S_XSR && timer_done) begin
                ref_owed <= 1'b1;
            end else if (state == S_REF) begin
                ref_owed <= 1'b0;
            end
            // Toggles per mask write: bank mask first, segment mask second
            if (state == S_MRW1) begin
                mrw_second <= !mrw_second;
            end
            // Accumulate self refresh time
            if (state == S_SELF || state == S_CLKUP) begin
                sr_time_out <= sr_time_out + 32'h00000001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Avalon-MM register access, one wait cycle per transfer
    always @(posedge clk_in) begin
        if (rst_in) begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= 32'h00000000;
            bank_mask <= `MASK_RESET;
            seg_mask <= `MASK_RESET;
            enter_req <= 1'b0;
            exit_req <= 1'b0;
            mrw_req <= 1'b0;
        end else begin
            avs_waitrequest_out <= 1'b1;
            // Requests clear as the sequencer takes them
            if (state == S_PRE) begin
                enter_req <= 1'b0;
            end
            if (state == S_CKEUP) begin
                exit_req <= 1'b0;
            end
            if (state == S_MRW1 && !mrw_second) begin
                mrw_req <= 1'b0;
            end
            if ((avs_read_in || avs_write_in) && avs_waitrequest_out) begin
                avs_waitrequest_out <= 1'b0;
                avs_readdata_out <= 32'h00000000;
                if (avs_write_in) begin
                    case (avs_address_in)
                        `REG_CTRL: begin
                            if (avs_writedata_in[`CTRL_ENTER_BIT]) enter_req <= 1'b1;
                            if (avs_writedata_in[`CTRL_EXIT_BIT]) exit_req <= 1'b1;
                            if (avs_writedata_in[`CTRL_MRW_BIT]) mrw_req <= 1'b1;
                        end
                        `REG_MASKS: begin
                            // Bit n masks bank/segment n
                            bank_mask <= avs_writedata_in[7:0];
                            seg_mask <= avs_writedata_in[15:8];
                        end
                        default: begin
                            enter_req <= enter_req;
                        end
                    endcase
                end else begin
                    case (avs_address_in)
                        `REG_CTRL: begin
                            avs_readdata_out <= {29'h0, mrw_req, exit_req, enter_req};
                        end
                        `REG_STATUS: begin
                            avs_readdata_out <= {24'h0, state, 1'b0, ref_owed,
                                (state == S_SELF || state == S_CLKUP),
                                (state != S_IDLE)};
                        end
                        `REG_MASKS: begin
                            avs_readdata_out <= {16'h0, seg_mask, bank_mask};
                        end
                        default: begin
                            avs_readdata_out <= 32'h00000000;
                        end
                    endcase
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- test/sr_device_model.sv ----
// Purpose: behavioural memory device seen by the controller
// Assumes: device clock is clk_in gated by ck_en_in
// Notes: internal timer runs on clk_in while in self refresh
`timescale 1ns/100ps
`default_nettype none
module sr_device_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Device pins
    input wire logic ck_en_in,
    input wire logic cke_in,
    input wire logic cs_n_in,
    input wire logic [9:0] ca_rise_in,
    input wire logic [9:0] ca_fall_in,
    // Observed state
    output logic [7:0] bank_mask_out,
    output logic [7:0] seg_mask_out,
    output logic in_sr_out,
    output logic [15:0] int_ref_out,
    output logic [15:0] ext_ref_out,
    output logic [63:0] keep_out
);
    logic [2:0] pb_bank;
    ////////////////////////////////////////////////////////////////
    // Command decode and self refresh state
    always @(posedge clk_in) begin
        if (rst_in) begin
            bank_mask_out <= 8'h00;
            seg_mask_out <= 8'h00;
            in_sr_out <= 1'b0;
            int_ref_out <= 16'h0;
            ext_ref_out <= 16'h0;
            pb_bank <= 3'h0;
        end else if (in_sr_out) begin
            int_ref_out <= int_ref_out + 16'h1;
            if (cke_in && ck_en_in) begin
                in_sr_out <= 1'b0;
            end
        end else if (ck_en_in && !cs_n_in) begin
            if (!cke_in && ca_rise_in[2:0] == 3'h4) begin
                in_sr_out <= 1'b1;
            end else if (cke_in && ca_rise_in[3:0] == 4'h0) begin
                case ({ca_rise_in[9:4], ca_fall_in[1:0]})
                    8'h10: bank_mask_out <= ca_fall_in[9:2];
                    8'h11: seg_mask_out <= ca_fall_in[9:2];
                    default: ;
                endcase
            end else if (cke_in && ca_rise_in[3:0] == 4'hc) begin
                ext_ref_out <= ext_ref_out + 16'h1;
                pb_bank <= 3'h0;
            end else if (cke_in && ca_rise_in[3:0] == 4'h4) begin
                pb_bank <= pb_bank + 3'h1;
            end
        end
    end
    // Refresh kept only where bank and segment are unmasked
    always @* begin
        for (int i = 0; i < 64; i++) begin
            keep_out[i] = !bank_mask_out[i / 8] && !seg_mask_out[i % 8];
        end
    end
endmodule
`default_nettype wire

// ---- test/sr_host_ctrl_asserts.sv ----
// Purpose: checks on the device pins and bus answer
// Assumes: one clock, synchronous reset
// Notes: exit delay 6 cycles, residency 1 cycle
`timescale 1ns/100ps
`default_nettype none
module sr_host_ctrl_asserts #(
    parameter TW = 16
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Bus
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic avs_waitrequest_out,
    // Device pins
    input wire logic ck_en_out,
    input wire logic cke_out,
    input wire logic cs_n_out,
    input wire logic [9:0] ca_rise_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    logic entry;
    logic all_bank_refresh;
    logic owed;
    ////////////////////////////////////////////////////////////////
    // Command decodes
    assign entry = !cke_out && !cs_n_out && ca_rise_out[2:0] == 3'h4;
    assign all_bank_refresh = cke_out && !cs_n_out && ca_rise_out[3:0] == 4'hc;
    // Refresh owed since the last exit
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            owed <= 1'b0;
        end else if ($rose(cke_out)) begin
            owed <= 1'b1;
        end else if (all_bank_refresh) begin
            owed <= 1'b0;
        end
    end
    sequence exit_start;
        $rose(cke_out);
    endsequence
    sequence nop_run;
        cs_n_out [*6];
    endsequence
    sequence cke_run;
        cke_out [*6];
    endsequence
    ////////////////////////////////////////////////////////////////
    pre_entry_cke_a: assert property (entry |-> $past(cke_out))
        else $error("CKE low before entry");
    entry_nop_a: assert property (entry |=> cs_n_out)
        else $error("No NOP after entry");
    sr_cke_low_a: assert property (!ck_en_out |-> !cke_out)
        else $error("CKE high while clock stopped");
    min_residency_a: assert property (entry |=> !cke_out)
        else $error("Exit before residency");
    clock_restart_a: assert property (exit_start |-> $past(ck_en_out, 1) && $past(ck_en_out, 2))
        else $error("Clock not stable before CKE");
    exit_nop_a: assert property (exit_start |-> nop_run)
        else $error("Command during exit delay");
    exit_cke_a: assert property (exit_start |-> cke_run)
        else $error("CKE fell during exit delay");
    owed_refresh_a: assert property (entry |-> !owed)
        else $error("Entry without refresh after exit");
    bus_answer_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
        |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
        else $error("Bus answer late");
endmodule
`default_nettype wire

// ---- test/sr_host_ctrl_bench.sv ----
// Purpose: register-level tests of the self refresh controller
// Assumes: 25 MHz clock, two-cycle bus transfers
// Notes: masks use banks 1,7 and segments 2,7
`timescale 1ns/100ps
`default_nettype none
`include "sr_ctrl_regs.vh"
module sr_host_ctrl_bench;
    localparam TW = 16;
    localparam [7:0] BM = 8'h82;
    localparam [7:0] SM = 8'h84;
    logic clk_in;
    logic rst_in;
    logic [1:0] avs_address_in;
    logic avs_read_in;
    logic avs_write_in;
    logic [31:0] avs_writedata_in;
    wire [31:0] avs_readdata_out;
    wire avs_waitrequest_out;
    wire ck_en_out;
    wire cke_out;
    wire cs_n_out;
    wire [9:0] ca_rise_out;
    wire [9:0] ca_fall_out;
    wire [31:0] sr_time_out;
    wire [7:0] bmask;
    wire [7:0] smask;
    wire in_sr;
    wire [15:0] int_ref;
    wire [15:0] ext_ref;
    wire [63:0] keep;
    integer fail_count;
    integer checks_done;
    logic [31:0] rd;
    logic [31:0] t1;
    ////////////////////////////////////////////////////////////////
    sr_host_ctrl #(.TW(TW)) dut (.clk_in(clk_in), .rst_in(rst_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .ck_en_out(ck_en_out), .cke_out(cke_out), .cs_n_out(cs_n_out),
        .ca_rise_out(ca_rise_out), .ca_fall_out(ca_fall_out), .sr_time_out(sr_time_out));
    sr_device_model mem (.clk_in(clk_in), .rst_in(rst_in), .ck_en_in(ck_en_out),
        .cke_in(cke_out), .cs_n_in(cs_n_out), .ca_rise_in(ca_rise_out),
        .ca_fall_in(ca_fall_out), .bank_mask_out(bmask), .seg_mask_out(smask),
        .in_sr_out(in_sr), .int_ref_out(int_ref), .ext_ref_out(ext_ref), .keep_out(keep));
    // Clock
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    ////////////////////////////////////////////////////////////////
    task check(input [31:0] got, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("BAD at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task xfer(input [1:0] a, input [31:0] d, input w);
        begin
            @(posedge clk_in);
            avs_address_in <= a;
            avs_writedata_in <= d;
            avs_write_in <= w;
            avs_read_in <= !w;
            @(posedge clk_in);
            // Ends when waitrequest goes low; it has no limit of its own, so only the watchdog ends a stuck wait
            while (avs_waitrequest_out !== 1'b0) begin
                @(posedge clk_in);
            end
            rd = avs_readdata_out;
            avs_write_in <= 1'b0;
            avs_read_in <= 1'b0;
        end
    endtask
    task wait_st(input [31:0] m, input [31:0] v);
        integer n;
        begin
            n = 0;
            xfer(`REG_STATUS, 32'h0, 1'b0);
            while ((rd & m) !== v && n < 200) begin
                xfer(`REG_STATUS, 32'h0, 1'b0);
                n = n + 1;
            end
            check(rd & m, v);
        end
    endtask
    task results;
        begin
            $display("Mismatches %0d, comparisons %0d", fail_count, checks_done);
            if (fail_count == 0 && checks_done > 0) begin
                $display("Finished cleanly");
            end else begin
                $display("Finished with errors");
            end
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    // Watchdog
    initial begin
        #200000;
        fail_count = fail_count + 1;
        $display("BAD at %0t: watchdog expired", $time);
        results;
    end
    // Main sequence
    initial begin
        fail_count = 0;
        checks_done = 0;
        t1 = 32'h0;
        rst_in = 1'b1;
        avs_address_in = 2'h0;
        avs_read_in = 1'b0;
        avs_write_in = 1'b0;
        avs_writedata_in = 32'h0;
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        wait_st(32'h7, 32'h0);
        xfer(`REG_MASKS, 32'h0, 1'b0);
        check(rd, 32'h0);
        check({16'h0, bmask, smask}, 32'h0);
        xfer(2'h3, 32'hffff, 1'b1);
        xfer(2'h3, 32'h0, 1'b0);
        check(rd, 32'h0);
        xfer(`REG_MASKS, {16'h0, SM, BM}, 1'b1);
        xfer(`REG_CTRL, 32'h1 << `CTRL_MRW_BIT, 1'b1);
        wait_st(32'h1, 32'h0);
        check({24'h0, bmask}, {24'h0, BM});
        check({24'h0, smask}, {24'h0, SM});
        for (int i = 0; i < 64; i++) begin
            check({31'h0, keep[i]}, {31'h0, !(BM[i / 8] || SM[i % 8])});
        end
        // Two stays, the second must first refresh
        for (int k = 0; k < 2; k++) begin
            xfer(`REG_CTRL, 32'h1 << `CTRL_ENTER_BIT, 1'b1);
            wait_st(32'h2, 32'h2);
            check({31'h0, in_sr}, 32'h1);
            check({31'h0, ck_en_out}, 32'h0);
            check(ext_ref, k);
            xfer(`REG_CTRL, 32'h1 << `CTRL_EXIT_BIT, 1'b1);
            wait_st(32'h7, 32'h4);
            check({31'h0, in_sr}, 32'h0);
            check({31'h0, sr_time_out > t1}, 32'h1);
            t1 = sr_time_out;
        end
        check({31'h0, int_ref !== 16'h0}, 32'h1);
        results;
    end
endmodule
bind sr_host_ctrl sr_host_ctrl_asserts #(.TW(TW)) chk (.clk_in(clk_in), .rst_in(rst_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_waitrequest_out(avs_waitrequest_out), .ck_en_out(ck_en_out),
    .cke_out(cke_out), .cs_n_out(cs_n_out), .ca_rise_out(ca_rise_out));
`default_nettype wire
